// [mbs_pkg.sv]
// Constants for the serial request/response server framing block.
// Assumes a 25 MHz ref_clk and a byte-wide receiver/transmitter outside.
package mbs_pkg;

	// --------------------------------------------------------------
	// Timing
	// --------------------------------------------------------------
	localparam int CLK_HZ = 25_000_000;
	localparam int BAUD_BPS = 19_200;
	// Start, 8 data, parity or second stop, stop
	localparam int CHAR_BITS = 11;
	// Silence of 3.5 characters, held as half characters
	localparam int GAP_HALF_CHARS = 7;
	localparam int GAP_CYCLES = int'((64'(CLK_HZ) * CHAR_BITS * GAP_HALF_CHARS
		+ 2 * BAUD_BPS - 1) / (2 * BAUD_BPS));

	// --------------------------------------------------------------
	// Frame layout
	// --------------------------------------------------------------
	localparam int FRAME_MAX = 40;
	localparam int MIN_FRAME = 4;
	localparam int FIXED_LEN = 8;
	localparam int DIAG_MIN_LEN = 6;
	localparam int WR_MULTI_HDR = 9;
	localparam int CRC_BYTES = 2;
	localparam int HDR_BYTES = 6;
	localparam int WR_ONE_DATA_IDX = 4;
	localparam int WR_MULTI_DATA_IDX = 7;
	localparam int ECHO_WR_ONE_LEN = 6;

	// --------------------------------------------------------------
	// Codes
	// --------------------------------------------------------------
	localparam logic [7:0] ADDR_BCAST = 8'h00;
	localparam logic [7:0] FN_RD_HOLD = 8'h03;
	localparam logic [7:0] FN_WR_ONE = 8'h06;
	localparam logic [7:0] FN_DIAG = 8'h08;
	localparam logic [7:0] FN_WR_MULTI = 8'h10;
	localparam logic [7:0] FN_ACC_LOG = 8'h46;
	localparam logic [15:0] SUB_ECHO = 16'h0000;
	localparam logic [7:0] EXC_FLAG = 8'h80;
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_ILL_FUNC = 8'h01;
	localparam logic [7:0] ERR_ILL_DATA = 8'h03;
	localparam logic [15:0] RD_QTY_MAX = 16'h007d;

	// --------------------------------------------------------------
	// Check value
	// --------------------------------------------------------------
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;
	localparam logic [15:0] CRC_RESIDUE = 16'h0000;

endpackage

// [mbs_crc_byte.sv]
// One byte step of the 16-bit frame check value.
// Pure combinational; the caller holds the running value.
module mbs_crc_byte
	import mbs_pkg::*;
(
	input wire logic [15:0] crc_in,
	input wire logic [7:0] data,
	output logic [15:0] crc_out
);

	// --------------------------------------------------------------
	// Bitwise shift, least significant bit first
	// --------------------------------------------------------------
	always_comb begin
		logic [15:0] c;
		c = crc_in ^ {8'h00, data};
		for (int i = 0; i < 8; i++) begin
			if (c[0]) begin
				c = (c >> 1) ^ CRC_POLY;
			end else begin
				c = c >> 1;
			end
		end
		crc_out = c;
	end

endmodule

// [mbs_server.sv]
// Server framing, check and dispatch for the serial request protocol.
// Assumes a byte receiver and transmitter on ref_clk, and a holding
// register store answering reg_req with a one-cycle reg_ack.
//
// Overview of operation
// - Normal reply echoes received address and function bytes first.
// - Error reply sets bit 7 of function code, error code follows.
// - Frames are bounded by 3.5 character times of silence.
// - Frame is address, function, data bytes, then two check bytes.
// - Accept own station number or broadcast; reply carries sent address.
// - Unsupported function codes draw an error reply.
// - Check value appended low byte first, then high byte.
// - Check value recomputed as bytes arrive; mismatch is an error.
// - Read holding registers supported, not executed on broadcast.
// - Write one register supported, also on broadcast.
// - Diagnostic sub-function zero echoes the query; not on broadcast.
// - Write many consecutive registers supported, also on broadcast.
// - Access log returns count and start of last register access.
// - After any other function the access log reports zeros.
// - Broadcast writes execute; no broadcast request ever gets a reply.
// - Framing or check faults discard the frame with no reply.
module mbs_server
	import mbs_pkg::*;
#(
	parameter int GAP_CYC = GAP_CYCLES,
	parameter int FRM_MAX = FRAME_MAX
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic [7:0] server_station_number_setting,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_fault,
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready,
	output logic reg_req,
	output logic reg_we,
	output logic [15:0] reg_addr,
	output logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_ack
);

	localparam int LW = $clog2(FRM_MAX + 1);
	localparam int GW = $clog2(GAP_CYC + 1);

	typedef enum logic [3:0] {
		S_RX, S_EVAL, S_WREQ, S_RREQ, S_HDR, S_RDH, S_RDL, S_ECHO,
		S_CRCL, S_CRCH
	} mbs_state_e;

	mbs_state_e state_q, after_q;
	logic [7:0] frm_q [FRM_MAX];
	logic [LW-1:0] len_q, echo_len_q, wr_idx_q, out_idx_q;
	logic bad_q;
	logic [GW-1:0] gap_cnt_q;
	logic [15:0] rx_crc_q, tx_crc_q, rx_crc_in, rx_crc_nx, tx_crc_nx;
	logic [7:0] hdr_q [HDR_BYTES];
	logic [2:0] hdr_len_q;
	logic [15:0] reg_ptr_q, rd_left_q, wr_left_q, rd_word_q;
	logic [15:0] log_start_q, log_cnt_q;
	logic req_q, we_q;
	logic [15:0] addr_q, wdata_q;
	logic [7:0] head_q, tail_q;
	logic head_v_q, tail_v_q;

	logic line_idle, frame_end, frame_ok, bcast;
	logic [7:0] f_addr, f_fn, f_bc, ev_err, push_d;
	logic [15:0] f_a, f_q, len16;
	logic push_v, push_ready, push_fire, pop;

	assign tx_valid = head_v_q;
	assign tx_data = head_q;
	assign reg_req = req_q;
	assign reg_we = we_q;
	assign reg_addr = addr_q;
	assign reg_wdata = wdata_q;

	// --------------------------------------------------------------
	// Silence detection
	// --------------------------------------------------------------
	assign line_idle = (gap_cnt_q == GW'(GAP_CYC));
	assign frame_end = !rx_valid && (gap_cnt_q == GW'(GAP_CYC - 1));

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			gap_cnt_q <= '0;
		end else if (ce) begin
			if (rx_valid) begin
				gap_cnt_q <= '0;
			end else if (!line_idle) begin
				gap_cnt_q <= gap_cnt_q + GW'(1);
			end
		end
	end

	// --------------------------------------------------------------
	// Frame capture
	// --------------------------------------------------------------
	// A byte that starts a frame without prior silence is a fragment
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			len_q <= '0;
			bad_q <= 1'b0;
		end else if (ce) begin
			if (state_q == S_EVAL) begin
				len_q <= '0;
				bad_q <= 1'b0;
			end else if (state_q == S_RX && rx_valid) begin
				if (len_q == '0 && !line_idle) begin
					bad_q <= 1'b1;
				end
				if (rx_fault || len_q == LW'(FRM_MAX)) begin
					bad_q <= 1'b1;
				end
				if (len_q != LW'(FRM_MAX)) begin
					frm_q[len_q] <= rx_data;
					len_q <= len_q + LW'(1);
				end
			end
		end
	end

	assign rx_crc_in = (len_q == '0) ? CRC_INIT : rx_crc_q;

	mbs_crc_byte u_rx_crc (
		.crc_in(rx_crc_in),
		.data(rx_data),
		.crc_out(rx_crc_nx)
	);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rx_crc_q <= CRC_INIT;
		end else if (ce && state_q == S_RX && rx_valid) begin
			rx_crc_q <= rx_crc_nx;
		end
	end

	// --------------------------------------------------------------
	// Request decode
	// --------------------------------------------------------------
	assign f_addr = frm_q[0];
	assign f_fn = frm_q[1];
	assign f_a = {frm_q[2], frm_q[3]};
	assign f_q = {frm_q[4], frm_q[5]};
	assign f_bc = frm_q[6];
	assign len16 = 16'(len_q);
	assign bcast = (f_addr == ADDR_BCAST);
	// Residue of zero over data plus check bytes means a match
	assign frame_ok = !bad_q && len16 >= 16'(MIN_FRAME)
		&& rx_crc_q == CRC_RESIDUE
		&& (f_addr == server_station_number_setting || bcast);

	always_comb begin
		ev_err = ERR_NONE;
		case (f_fn)
			FN_RD_HOLD: begin
				if (len16 != 16'(FIXED_LEN) || f_q == 16'h0000
					|| f_q > RD_QTY_MAX) begin
					ev_err = ERR_ILL_DATA;
				end
			end
			FN_WR_ONE: begin
				if (len16 != 16'(FIXED_LEN)) begin
					ev_err = ERR_ILL_DATA;
				end
			end
			FN_DIAG: begin
				if (len16 < 16'(DIAG_MIN_LEN)) begin
					ev_err = ERR_ILL_DATA;
				end else if (f_a != SUB_ECHO) begin
					ev_err = ERR_ILL_FUNC;
				end
			end
			FN_WR_MULTI: begin
				if (len16 != 16'(WR_MULTI_HDR) + {8'h00, f_bc}
					|| f_q == 16'h0000
					|| {8'h00, f_bc} != {f_q[14:0], 1'b0}) begin
					ev_err = ERR_ILL_DATA;
				end
			end
			FN_ACC_LOG: begin
				if (len16 != 16'(MIN_FRAME)) begin
					ev_err = ERR_ILL_DATA;
				end
			end
			default: begin
				ev_err = ERR_ILL_FUNC;
			end
		endcase
	end

	// --------------------------------------------------------------
	// Sequencer
	// --------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_q <= S_RX;
			after_q <= S_RX;
			out_idx_q <= '0;
			echo_len_q <= '0;
			wr_idx_q <= '0;
			hdr_len_q <= '0;
			reg_ptr_q <= '0;
			rd_left_q <= '0;
			wr_left_q <= '0;
			rd_word_q <= '0;
			req_q <= 1'b0;
			we_q <= 1'b0;
			addr_q <= '0;
			wdata_q <= '0;
			for (int i = 0; i < HDR_BYTES; i++) begin
				hdr_q[i] <= '0;
			end
		end else if (ce) begin
			case (state_q)
				S_RX: begin
					if (frame_end && len_q != '0) begin
						state_q <= S_EVAL;
					end
				end
				S_EVAL: begin
					out_idx_q <= '0;
					rd_left_q <= '0;
					hdr_q[0] <= f_addr;
					hdr_q[1] <= f_fn;
					if (!frame_ok) begin
						state_q <= S_RX;
					end else if (ev_err != ERR_NONE) begin
						hdr_q[1] <= f_fn | EXC_FLAG;
						hdr_q[2] <= ev_err;
						hdr_len_q <= 3'd3;
						state_q <= bcast ? S_RX : S_HDR;
					end else begin
						case (f_fn)
							FN_RD_HOLD: begin
								hdr_q[2] <= {f_q[6:0], 1'b0};
								hdr_len_q <= 3'd3;
								rd_left_q <= f_q;
								reg_ptr_q <= f_a;
								state_q <= bcast ? S_RX : S_HDR;
							end
							FN_WR_ONE: begin
								reg_ptr_q <= f_a;
								wr_left_q <= 16'h0001;
								wr_idx_q <= LW'(WR_ONE_DATA_IDX);
								echo_len_q <= LW'(ECHO_WR_ONE_LEN);
								after_q <= bcast ? S_RX : S_ECHO;
								state_q <= S_WREQ;
							end
							FN_DIAG: begin
								echo_len_q <= LW'(len_q - LW'(CRC_BYTES));
								state_q <= bcast ? S_RX : S_ECHO;
							end
							FN_WR_MULTI: begin
								reg_ptr_q <= f_a;
								wr_left_q <= f_q;
								wr_idx_q <= LW'(WR_MULTI_DATA_IDX);
								hdr_q[2] <= frm_q[2];
								hdr_q[3] <= frm_q[3];
								hdr_q[4] <= frm_q[4];
								hdr_q[5] <= frm_q[5];
								hdr_len_q <= 3'd6;
								after_q <= bcast ? S_RX : S_HDR;
								state_q <= S_WREQ;
							end
							FN_ACC_LOG: begin
								hdr_q[2] <= log_cnt_q[15:8];
								hdr_q[3] <= log_cnt_q[7:0];
								hdr_q[4] <= log_start_q[15:8];
								hdr_q[5] <= log_start_q[7:0];
								hdr_len_q <= 3'd6;
								state_q <= bcast ? S_RX : S_HDR;
							end
							default: begin
								state_q <= S_RX;
							end
						endcase
					end
				end
				// Broadcast writes run here too; only the reply is skipped
				S_WREQ: begin
					if (req_q) begin
						if (reg_ack) begin
							req_q <= 1'b0;
							reg_ptr_q <= reg_ptr_q + 16'h0001;
							wr_idx_q <= wr_idx_q + LW'(2);
							wr_left_q <= wr_left_q - 16'h0001;
						end
					end else if (wr_left_q == 16'h0000) begin
						state_q <= after_q;
					end else begin
						req_q <= 1'b1;
						we_q <= 1'b1;
						addr_q <= reg_ptr_q;
						wdata_q <= {frm_q[wr_idx_q],
							frm_q[LW'(wr_idx_q + LW'(1))]};
					end
				end
				S_RREQ: begin
					if (req_q) begin
						if (reg_ack) begin
							req_q <= 1'b0;
							rd_word_q <= reg_rdata;
							reg_ptr_q <= reg_ptr_q + 16'h0001;
							state_q <= S_RDH;
						end
					end else begin
						req_q <= 1'b1;
						we_q <= 1'b0;
						addr_q <= reg_ptr_q;
					end
				end
				S_HDR: begin
					if (push_fire) begin
						if (out_idx_q == LW'(hdr_len_q - 3'd1)) begin
							out_idx_q <= '0;
							state_q <= (rd_left_q != 16'h0000) ? S_RREQ : S_CRCL;
						end else begin
							out_idx_q <= out_idx_q + LW'(1);
						end
					end
				end
				S_RDH: begin
					if (push_fire) begin
						state_q <= S_RDL;
					end
				end
				S_RDL: begin
					if (push_fire) begin
						rd_left_q <= rd_left_q - 16'h0001;
						state_q <= (rd_left_q == 16'h0001) ? S_CRCL : S_RREQ;
					end
				end
				S_ECHO: begin
					if (push_fire) begin
						if (out_idx_q == echo_len_q - LW'(1)) begin
							state_q <= S_CRCL;
						end else begin
							out_idx_q <= out_idx_q + LW'(1);
						end
					end
				end
				S_CRCL: begin
					if (push_fire) begin
						state_q <= S_CRCH;
					end
				end
				S_CRCH: begin
					if (push_fire) begin
						state_q <= S_RX;
					end
				end
				default: begin
					state_q <= S_RX;
				end
			endcase
		end
	end

	// --------------------------------------------------------------
	// Access log
	// --------------------------------------------------------------
	// Any accepted frame other than a register access clears the log
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			log_start_q <= '0;
			log_cnt_q <= '0;
		end else if (ce && state_q == S_EVAL && frame_ok) begin
			if (ev_err == ERR_NONE && (f_fn == FN_WR_MULTI
				|| (f_fn == FN_RD_HOLD && !bcast))) begin
				log_start_q <= f_a;
				log_cnt_q <= f_q;
			end else if (ev_err == ERR_NONE && f_fn == FN_WR_ONE) begin
				log_start_q <= f_a;
				log_cnt_q <= 16'h0001;
			end else begin
				log_start_q <= '0;
				log_cnt_q <= '0;
			end
		end
	end

	// --------------------------------------------------------------
	// Reply byte source and check value
	// --------------------------------------------------------------
	always_comb begin
		push_v = 1'b1;
		case (state_q)
			S_HDR: push_d = hdr_q[out_idx_q[2:0]];
			S_RDH: push_d = rd_word_q[15:8];
			S_RDL: push_d = rd_word_q[7:0];
			S_ECHO: push_d = frm_q[out_idx_q];
			S_CRCL: push_d = tx_crc_q[7:0];
			S_CRCH: push_d = tx_crc_q[15:8];
			default: begin
				push_v = 1'b0;
				push_d = 8'h00;
			end
		endcase
	end

	assign push_ready = !tail_v_q;
	assign push_fire = push_v && push_ready;
	assign pop = head_v_q && tx_ready;

	mbs_crc_byte u_tx_crc (
		.crc_in(tx_crc_q),
		.data(push_d),
		.crc_out(tx_crc_nx)
	);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tx_crc_q <= CRC_INIT;
		end else if (ce) begin
			if (state_q == S_EVAL) begin
				tx_crc_q <= CRC_INIT;
			end else if (push_fire && state_q != S_CRCL
				&& state_q != S_CRCH) begin
				tx_crc_q <= tx_crc_nx;
			end
		end
	end

	// --------------------------------------------------------------
	// Two-entry output buffer
	// --------------------------------------------------------------
	// Tail only fills while the head is stalled, so no byte is lost
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			head_q <= '0;
			tail_q <= '0;
			head_v_q <= 1'b0;
			tail_v_q <= 1'b0;
		end else if (ce) begin
			if (pop) begin
				if (tail_v_q) begin
					head_q <= tail_q;
					tail_v_q <= 1'b0;
				end else if (push_fire) begin
					head_q <= push_d;
				end else begin
					head_v_q <= 1'b0;
				end
			end else if (push_fire) begin
				if (!head_v_q) begin
					head_q <= push_d;
					head_v_q <= 1'b1;
				end else begin
					tail_q <= push_d;
					tail_v_q <= 1'b1;
				end
			end
		end
	end

endmodule

// [mbs_server_sva.sv]
// Checker for the server framing block, bound to mbs_server.
// Sees only the top ports; one clock, synchronous reset.
module mbs_server_sva
	import mbs_pkg::*;
#(
	parameter int GAP_CYC = GAP_CYCLES
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic [7:0] server_station_number_setting,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_ready,
	input wire logic reg_req,
	input wire logic reg_we,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_ack
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);
	// ----------------------------------------
	// Frame tracking
	// ----------------------------------------
	int quiet_q, idx_q;
	logic [7:0] addr_q, func_q;
	logic second_q;
	// Saturates so a long idle line never wraps
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			quiet_q <= 0;
			second_q <= 1'b0;
		end else if (ce && rx_valid) begin
			quiet_q <= 0;
			second_q <= quiet_q >= GAP_CYC - 1;
			if (quiet_q >= GAP_CYC - 1) addr_q <= rx_data;
			if (second_q) func_q <= rx_data;
		end else if (ce && quiet_q < GAP_CYC) begin
			quiet_q <= quiet_q + 1;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (srst || rx_valid) idx_q <= 0;
		else if (ce && tx_valid && tx_ready) idx_q <= idx_q + 1;
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	AST_GAP_QUIET: assert property (
		($rose(tx_valid) || $rose(reg_req)) |-> quiet_q >= GAP_CYC - 1)
		else $error("reply or access before frame gap");
	AST_REPLY_ADDR: assert property (
		tx_valid && idx_q == 0 |-> tx_data == addr_q)
		else $error("first reply byte is not the address");
	AST_REPLY_FUNC: assert property (
		tx_valid && idx_q == 1 |-> tx_data[6:0] == func_q[6:0]
		&& (tx_data[7] || !func_q[7]))
		else $error("second reply byte is not the function");
	AST_OWN_STATION: assert property (
		tx_valid |-> addr_q == server_station_number_setting)
		else $error("reply to a frame for another station");
	AST_BCAST_SILENT: assert property (
		tx_valid |-> addr_q != ADDR_BCAST)
		else $error("reply to a broadcast");
	AST_BCAST_NO_READ: assert property (
		reg_req |-> reg_we || addr_q != ADDR_BCAST)
		else $error("read executed on broadcast");
	AST_REQ_HOLD: assert property (
		reg_req && !reg_ack |=> reg_req && $stable(reg_addr)
		&& $stable(reg_wdata) && $stable(reg_we))
		else $error("register request changed before ack");
	AST_REQ_DROP: assert property (
		reg_req && reg_ack && ce |=> !reg_req)
		else $error("register request held after ack");
	AST_TX_HOLD: assert property (
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("reply byte changed before taken");
endmodule

bind mbs_server mbs_server_sva #(.GAP_CYC(GAP_CYC)) u_sva (
	.ref_clk(ref_clk), .srst(srst), .ce(ce),
	.server_station_number_setting(server_station_number_setting),
	.rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
	.tx_data(tx_data), .tx_ready(tx_ready), .reg_req(reg_req),
	.reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_ack(reg_ack));

// [mbs_client_model.sv]
// Far side: transmitter sink with stalls and a register store.
// Drives on the falling edge; read data is a fixed mask of the address.
module mbs_client_model #(
	parameter logic [15:0] MASK = 16'h5a3c
) (
	input wire logic ref_clk,
	input wire logic reg_req,
	input wire logic [15:0] reg_addr,
	output logic reg_ack,
	output logic [15:0] reg_rdata,
	output logic tx_ready
);
	int s = 20;
	initial begin
		reg_ack = 1'b0;
		tx_ready = 1'b0;
	end
	// Released data is inverted so a stale sample cannot match
	assign reg_rdata = reg_req ? reg_addr ^ MASK : ~reg_addr;
	// Random stalls fill the two-entry reply buffer
	always @(negedge ref_clk) begin
		tx_ready <= $random(s) & 1;
		reg_ack <= reg_req && !reg_ack && ($random(s) & 1);
	end
endmodule

// [mbs_server_bench.sv]
// Self-checking bench for mbs_server with a short frame gap.
// Uses mbs_client_model as transmitter sink and register store.
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
	errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module mbs_server_bench
	import mbs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int GAP = 20;
	localparam logic [15:0] MASK = 16'h5a3c;
	typedef logic [7:0] mbs_tb_byte_t;
	logic ref_clk = 1'b0;
	logic srst, rx_valid, rx_fault, tx_valid, tx_ready, reg_req, reg_we;
	logic reg_ack, ce;
	logic [7:0] st, rx_data, tx_data;
	logic [15:0] reg_addr, reg_wdata, reg_rdata, a, d;
	logic [8:0] e9;
	logic [32:0] e33;
	mbs_tb_byte_t q[$], r[$], none[$], txq[$];
	mbs_tb_byte_t bad_fn[3] = '{8'h01, 8'h41, 8'hc5};
	logic [32:0] regq[$];
	int seed = 20, errors = 0, total_checks = 0, n, i;

	mbs_server #(.GAP_CYC(GAP), .FRM_MAX(FRAME_MAX)) dut (
		.ref_clk(ref_clk), .srst(srst), .ce(ce),
		.server_station_number_setting(st), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_fault(rx_fault), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready), .reg_req(reg_req),
		.reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_ack(reg_ack));
	mbs_client_model #(.MASK(MASK)) peer (
		.ref_clk(ref_clk), .reg_req(reg_req), .reg_addr(reg_addr),
		.reg_ack(reg_ack), .reg_rdata(reg_rdata), .tx_ready(tx_ready));

	always #20 ref_clk = ~ref_clk;
	// ----------------------------------------
	// Result watcher
	// ----------------------------------------
	always @(posedge ref_clk) begin
		if (!srst && ce && tx_valid && tx_ready) begin
			e9 = txq.size() ? {1'b0, txq.pop_front()} : 9'h100;
			`CHK("tx_data", e9, {1'b0, tx_data})
		end
		if (!srst && ce && reg_req && reg_ack) begin
			e33 = regq.size() ? regq.pop_front() : '1;
			`CHK("reg", e33, {reg_we, reg_addr, reg_we ? reg_wdata : 16'h0})
		end
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	function automatic logic [15:0] crc16(input mbs_tb_byte_t b[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (b[k]) begin
			c ^= {8'h00, b[k]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		end
		return c;
	endfunction

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Bad: 1 check value, 2 byte fault, 3 other station
	task automatic xfer(string nm, mbs_tb_byte_t f[$], mbs_tb_byte_t p[$],
		int bad);
		logic [15:0] c;
		int w;
		if (bad == 3) f[0] = f[0] + 8'h01;
		c = crc16(f);
		f.push_back(c[7:0]);
		f.push_back(c[15:8]);
		if (bad == 1) f[f.size() - 1] ^= 8'h01;
		c = crc16(p);
		if (p.size()) p = {p, c[7:0], c[15:8]};
		txq = {txq, p};
		repeat (GAP + 2) @(negedge ref_clk);
		foreach (f[j]) begin
			rx_valid = 1'b1;
			rx_data = f[j];
			rx_fault = bad == 2 && j == 2;
			@(negedge ref_clk);
			w = {$random(seed)} % 3;
			// Back to back bytes keep the strobe up instead of re-raising it
			if (w || j == f.size() - 1) begin
				rx_valid = 1'b0;
				rx_data = ~f[j];
				rx_fault = 1'b0;
				repeat (w) @(negedge ref_clk);
			end
		end
		w = 0;
		// Random freezes while the reply and the register accesses drain
		while ((txq.size() || regq.size()) && w < 3000) begin
			ce = ({$random(seed)} % 4) != 0;
			@(negedge ref_clk);
			w++;
		end
		ce = 1'b1;
		if (w == 3000) begin
			errors++;
			test_done();
		end
		repeat (2 * GAP + 8) @(negedge ref_clk);
		$display("test %s done", nm);
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		st = 8'(1 + {$random(seed)} % 247);
		srst = 1'b1;
		ce = 1'b1;
		rx_valid = 1'b0;
		rx_fault = 1'b0;
		rx_data = 8'h00;
		repeat (2) @(negedge ref_clk);
		srst = 1'b0;
		a = $random(seed);
		n = 1 + {$random(seed)} % 3;
		q = '{st, FN_RD_HOLD, a[15:8], a[7:0], 8'h00, 8'(n)};
		r = '{st, FN_RD_HOLD, 8'(2 * n)};
		for (i = 0; i < n; i++) begin
			d = (a + 16'(i)) ^ MASK;
			r = {r, d[15:8], d[7:0]};
			regq.push_back({1'b0, a + 16'(i), 16'h0000});
		end
		xfer("read", q, r, 0);
		d = $random(seed);
		q = '{st, FN_WR_ONE, a[15:8], a[7:0], d[15:8], d[7:0]};
		regq.push_back({1'b1, a, d});
		xfer("wr_one", q, q, 0);
		q[0] = ADDR_BCAST;
		regq.push_back({1'b1, a, d});
		xfer("bc_wr_one", q, none, 0);
		q = '{ADDR_BCAST, FN_WR_MULTI, a[15:8], a[7:0], 8'h00, 8'(n),
			8'(2 * n)};
		for (i = 0; i < n; i++) begin
			d = $random(seed);
			q = {q, d[15:8], d[7:0]};
			regq.push_back({1'b1, a + 16'(i), d});
		end
		xfer("bc_wr_multi", q, none, 0);
		q[0] = st;
		for (i = 0; i < n; i++) begin
			regq.push_back({1'b1, a + 16'(i), q[7 + 2 * i], q[8 + 2 * i]});
		end
		r = '{st, FN_WR_MULTI, a[15:8], a[7:0], 8'h00, 8'(n)};
		xfer("wr_multi", q, r, 0);
		q = '{st, FN_ACC_LOG};
		r = '{st, FN_ACC_LOG, 8'h00, 8'(n), a[15:8], a[7:0]};
		xfer("log", q, r, 0);
		r = '{st, FN_ACC_LOG, 8'h00, 8'h00, 8'h00, 8'h00};
		xfer("log_zero", q, r, 0);
		q = '{st, FN_DIAG, 8'h00, 8'h00, 8'($random(seed)), 8'h7f};
		xfer("diag", q, q, 0);
		q[3] = 8'h01;
		r = '{st, FN_DIAG | EXC_FLAG, ERR_ILL_FUNC};
		xfer("bad_sub", q, r, 0);
		foreach (bad_fn[k]) begin
			q = '{st, bad_fn[k]};
			r = '{st, bad_fn[k] | EXC_FLAG, ERR_ILL_FUNC};
			xfer("bad_func", q, r, 0);
		end
		for (i = 0; i < 2; i++) begin
			q = '{st, FN_RD_HOLD, 8'h00, 8'h00, 8'h00, i ? 8'h7e : 8'h00};
			r = '{st, FN_RD_HOLD | EXC_FLAG, ERR_ILL_DATA};
			xfer("bad_qty", q, r, 0);
		end
		q = '{st, FN_WR_ONE, 8'h00, 8'h01, 8'h12, 8'h34};
		for (i = 1; i < 4; i++) xfer("drop", q, none, i);
		q = '{ADDR_BCAST, FN_RD_HOLD, 8'h00, 8'h00, 8'h00, 8'h01};
		xfer("bc_read", q, none, 0);
		test_done();
	end
endmodule
